// ==== mai_audio_input_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mai_consts.svh"
module mai_audio_input_port
  import mai_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic frame_sync_in,
  input wire logic serial_bit_clock_in,
  input wire logic audio_master_clock_in,
  input wire logic serial_audio_in_1,
  input wire logic serial_audio_in_2,
  input wire logic serial_audio_in_3,
  input wire logic serial_audio_in_4,
  input wire mai_cfg_s cfg,
  output mai_chan_t output_channel_a,
  output mai_chan_t output_channel_b,
  output logic frame_valid,
  output mai_rate_s rate_status,
  output logic rate_conv_tick
);

  function automatic mai_word_t left_align(input mai_word_t w, input logic [4:0] n);
    logic [4:0] sh;
    sh = 5'(`MAI_SAMPLE_W) - n;
    return (n == 5'h00) ? `MAI_SAMPLE_RST : (w << sh);
  endfunction

  function automatic mai_word_t deemph(input mai_word_t x, input mai_word_t y,
                                       input logic [7:0] k);
    logic signed [24:0] diff;
    logic signed [33:0] prod;
    logic signed [25:0] sum;
    diff = $signed({x[23], x}) - $signed({y[23], y});
    prod = 34'(diff * $signed({1'b0, k}));
    sum = $signed({{2{y[23]}}, y}) + $signed(prod[33:8]);
    return sum[23:0];
  endfunction

  function automatic mai_ratio_e classify(input logic [`MAI_MCK_CNT_W-1:0] n,
                                          input logic dbl);
    mai_ratio_e r;
    if (n < `MAI_THR_192) r = ratio_128;
    else if (n < `MAI_THR_256) r = ratio_192;
    else if (n < `MAI_THR_384) r = ratio_256;
    else if (n < `MAI_THR_512) r = ratio_384;
    else if (n < `MAI_THR_768) r = ratio_512;
    else if (n < `MAI_THR_1024) r = ratio_768;
    else if (n < `MAI_THR_NONE) r = ratio_1024;
    else r = ratio_none;
    if (dbl && r > ratio_512) r = ratio_none;
    if (!dbl && r < ratio_256) r = ratio_none;
    return r;
  endfunction

  function automatic logic [4:0] ratio_div(input mai_ratio_e r);
    unique case (r)
      ratio_128: return 5'h02;
      ratio_192: return 5'h03;
      ratio_256: return 5'h04;
      ratio_384: return 5'h06;
      ratio_512: return 5'h08;
      ratio_768: return 5'h0c;
      ratio_1024: return 5'h10;
      ratio_none: return 5'h00;
    endcase
  endfunction

  // Pins only ever sampled, never driven
  mai_pins_s pins_raw, meta_q, sync_q, last_q;
  assign pins_raw = {frame_sync_in, serial_bit_clock_in, audio_master_clock_in,
                     serial_audio_in_4, serial_audio_in_3, serial_audio_in_2, serial_audio_in_1};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  logic bck_rise, mck_rise, fs_rise_ref;
  assign bck_rise = sync_q.bck & ~last_q.bck;
  assign mck_rise = sync_q.mck & ~last_q.mck;
  assign fs_rise_ref = sync_q.fs & ~last_q.fs;

  mai_fmt_e fmt;
  logic is_frame;
  assign fmt = cfg.fmt;
  assign is_frame = (fmt == fmt_ol1) || (fmt == fmt_ol2) || (fmt == fmt_tdm);

  // Two-channel formats
  logic lr_prev_q, trans, shift_en, left_done;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] nsh_q;
  mai_chan_t sh_q;
  assign trans = sync_q.fs ^ lr_prev_q;
  assign cnt_d = trans ? 6'h00 : ((cnt_q == `MAI_BIT_CNT_MAX) ? cnt_q : cnt_q + 6'h01);
  assign left_done = (fmt == fmt_i2s) ? ~lr_prev_q : lr_prev_q;

  always_comb begin
    unique case (fmt)
      fmt_lj: shift_en = cnt_d < 6'(`MAI_SAMPLE_W);
      fmt_i2s: shift_en = (cnt_d != 6'h00) && (cnt_d <= 6'(`MAI_SAMPLE_W));
      default: shift_en = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lr_prev_q <= 1'b0;
      cnt_q <= 6'h00;
      nsh_q <= 5'h00;
      sh_q <= '0;
    end else if (bck_rise) begin
      lr_prev_q <= sync_q.fs;
      cnt_q <= cnt_d;
      if (shift_en) begin
        for (int i = 0; i < 4; i++) begin
          sh_q[i] <= {sh_q[i][`MAI_SAMPLE_W-2:0], sync_q.sd[i]};
        end
      end
      if (trans) nsh_q <= {4'h0, shift_en};
      else if (shift_en && nsh_q < 5'(`MAI_SAMPLE_W)) nsh_q <= nsh_q + 5'h01;
    end
  end

  // One-line and TDM framing
  logic fs_edge, tdm_arm_q, fr_start, fr_active, slot_end, last_slot;
  logic [7:0] pos_q, cur_pos, half;
  logic [3:0] slot_q, cur_slot, nslots;
  logic [4:0] sbit_q, cur_bit, cw;
  logic [5:0] slot_w;
  logic [1:0][`MAI_SAMPLE_W-1:0] fsh_q, fsh_d;

  assign fs_edge = sync_q.fs & ~lr_prev_q;
  assign fr_start = (fmt == fmt_tdm) ? tdm_arm_q : fs_edge;

  always_comb begin
    unique case (fmt)
      fmt_ol1: begin
        slot_w = {1'b0, `MAI_OL1_SLOT_W};
        half = `MAI_OL1_HALF;
        nslots = `MAI_OL_SLOTS;
      end
      fmt_ol2: begin
        slot_w = {1'b0, `MAI_OL2_SLOT_W};
        half = `MAI_OL2_HALF;
        nslots = `MAI_OL_SLOTS;
      end
      default: begin
        slot_w = `MAI_TDM_SLOT_W;
        half = `MAI_POS_MAX;
        nslots = `MAI_TDM_SLOTS;
      end
    endcase
    // Bits past the 24th of a slot are dropped
    cw = (slot_w > 6'(`MAI_SAMPLE_W)) ? 5'(`MAI_SAMPLE_W) : slot_w[4:0];
    cur_pos = fr_start ? 8'h00 : pos_q;
    cur_slot = fr_start ? 4'h0 : slot_q;
    cur_bit = fr_start ? 5'h00 : sbit_q;
    if (fmt != fmt_tdm && cur_pos == half) begin
      cur_slot = `MAI_OL_SECOND_SLOT;
      cur_bit = 5'h00;
    end
    fr_active = cur_slot < nslots;
    slot_end = fr_active && ({1'b0, cur_bit} == slot_w - 6'h01);
    last_slot = cur_slot == nslots - 4'h1;
    fsh_d = fsh_q;
    if (fr_active && cur_bit < cw) begin
      fsh_d[0] = {fsh_q[0][`MAI_SAMPLE_W-2:0], sync_q.sd[0]};
      fsh_d[1] = {fsh_q[1][`MAI_SAMPLE_W-2:0], sync_q.sd[3]};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tdm_arm_q <= 1'b0;
      pos_q <= `MAI_POS_MAX;
      slot_q <= `MAI_TDM_SLOTS;
      sbit_q <= 5'h00;
      fsh_q <= '0;
    end else if (bck_rise && is_frame) begin
      tdm_arm_q <= fs_edge;
      pos_q <= (cur_pos == `MAI_POS_MAX) ? cur_pos : cur_pos + 8'h01;
      fsh_q <= fsh_d;
      if (slot_end) begin
        slot_q <= cur_slot + 4'h1;
        sbit_q <= 5'h00;
      end else begin
        slot_q <= cur_slot;
        sbit_q <= fr_active ? cur_bit + 5'h01 : cur_bit;
      end
    end
  end

  // Staging: a whole frame is collected before it is presented
  logic [7:0][`MAI_SAMPLE_W-1:0] stage_q;
  logic frame_done_q;
  logic [2:0] l1_idx;

  assign l1_idx = (fmt == fmt_tdm || cur_slot < `MAI_OL_SECOND_SLOT) ?
                  cur_slot[2:0] : 3'(cur_slot + 4'h1);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage_q <= '0;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= 1'b0;
      if (bck_rise && !is_frame && trans) begin
        for (int i = 0; i < 4; i++) begin
          if (fmt == fmt_rj16) begin
            stage_q[left_done ? i : i + 4] <= {sh_q[i][`MAI_RJ16_W-1:0],
                                               8'h00};
          end else if (fmt == fmt_rj24) begin
            stage_q[left_done ? i : i + 4] <= sh_q[i];
          end else begin
            stage_q[left_done ? i : i + 4] <= left_align(sh_q[i], nsh_q);
          end
        end
        frame_done_q <= !left_done;
      end
      if (bck_rise && is_frame && slot_end) begin
        stage_q[l1_idx] <= left_align(fsh_d[0], cw);
        if (fmt != fmt_tdm && cur_slot == 4'h0) stage_q[3] <= left_align(fsh_d[1], cw);
        if (fmt != fmt_tdm && cur_slot == `MAI_OL_SECOND_SLOT) begin
          stage_q[7] <= left_align(fsh_d[1], cw);
        end
        frame_done_q <= last_slot;
      end
    end
  end

  // Output with optional de-emphasis; the filter state is the previous output
  mai_chan_t outa_q, outb_q;
  logic frame_valid_q;
  logic [7:0] deemph_k;

  always_comb begin
    unique case (cfg.deemph)
      deemph_32k: deemph_k = `MAI_DEEMPH_K32;
      deemph_44k1: deemph_k = `MAI_DEEMPH_K44;
      deemph_48k: deemph_k = `MAI_DEEMPH_K48;
      deemph_off: deemph_k = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      outa_q <= '0;
      outb_q <= '0;
      frame_valid_q <= 1'b0;
    end else begin
      frame_valid_q <= frame_done_q;
      if (frame_done_q) begin
        for (int i = 0; i < 4; i++) begin
          outa_q[i] <= (cfg.deemph == deemph_off) ? stage_q[i] :
                       deemph(stage_q[i], outa_q[i], deemph_k);
          outb_q[i] <= (cfg.deemph == deemph_off) ? stage_q[i + 4] :
                       deemph(stage_q[i + 4], outb_q[i], deemph_k);
        end
      end
    end
  end

  assign output_channel_a = outa_q;
  assign output_channel_b = outb_q;
  assign frame_valid = frame_valid_q;

  // Ratio detect: count master clock edges per frame sync period
  logic [`MAI_MCK_CNT_W-1:0] mcnt_q;
  mai_ratio_e ratio_q;
  logic [4:0] divcnt_q, div;
  logic tick_q;
  assign div = ratio_div(ratio_q);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mcnt_q <= '0;
      ratio_q <= ratio_none;
    end else if (fs_rise_ref) begin
      mcnt_q <= {{(`MAI_MCK_CNT_W-1){1'b0}}, mck_rise};
      ratio_q <= classify(mcnt_q, cfg.double_speed);
    end else if (mck_rise && mcnt_q != `MAI_MCK_CNT_MAX) begin
      mcnt_q <= mcnt_q + 11'h001;
    end
  end

  // Converter clock: one tick every div master clock edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      divcnt_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (ratio_q == ratio_none) begin
        divcnt_q <= 5'h00;
      end else if (mck_rise) begin
        if (divcnt_q >= div - 5'h01) begin
          divcnt_q <= 5'h00;
          tick_q <= 1'b1;
        end else begin
          divcnt_q <= divcnt_q + 5'h01;
        end
      end
    end
  end

  assign rate_status = '{ratio: ratio_q, locked: ratio_q != ratio_none, div: div};
  assign rate_conv_tick = tick_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_edge_trans;
    bck_rise && !is_frame && trans;
  endsequence

  a_frame_single_pulse: assert property (frame_valid |=> !frame_valid)
    else $error("frame valid lasted more than one cycle");
  a_i2s_skip_first: assert property (s_edge_trans ##0 fmt == fmt_i2s |=> $stable(sh_q))
    else $error("I2S shifted on the frame sync edge");
  a_lj_takes_first: assert property (s_edge_trans ##0 fmt == fmt_lj
      |=> sh_q[0][0] == $past(sync_q.sd[0]))
    else $error("left-justified missed the first bit");
  a_i2s_right_slot: assert property (s_edge_trans ##0 fmt == fmt_i2s ##0 !sync_q.fs
      |=> stage_q[4] == $past(left_align(sh_q[0], nsh_q)) && frame_done_q)
    else $error("I2S right word misplaced");
  a_lj_pair_map: assert property (s_edge_trans ##0 fmt == fmt_lj ##0 !sync_q.fs
      |=> stage_q[1] == $past(left_align(sh_q[1], nsh_q)) && !frame_done_q)
    else $error("left word of input 2 misplaced");
  a_rj16_align: assert property (s_edge_trans ##0 fmt == fmt_rj16 ##0 !sync_q.fs
      |=> stage_q[0][7:0] == 8'h00 && stage_q[0][23:8] == $past(sh_q[0][15:0]))
    else $error("right-justified 16-bit word misaligned");
  a_ol_frame_start: assert property (bck_rise && fmt == fmt_ol1 && fs_edge
      |=> pos_q == 8'h01 && slot_q == 4'h0)
    else $error("one-line frame did not start on frame sync edge");
  a_tdm_late_start: assert property (bck_rise && fmt == fmt_tdm && fs_edge |=> tdm_arm_q)
    else $error("TDM frame sync was not armed");
  a_tdm_arm_start: assert property (bck_rise && fmt == fmt_tdm && tdm_arm_q
      |=> pos_q == 8'h01)
    else $error("TDM frame did not start one bit after frame sync");
  a_tdm_pass_map: assert property (frame_done_q && fmt == fmt_tdm && cfg.deemph == deemph_off
      |=> output_channel_a[3] == $past(stage_q[3]) && output_channel_b[3] == $past(stage_q[7])
          && frame_valid)
    else $error("TDM channels not presented as collected");
  a_ratio_restart: assert property (fs_rise_ref |=> mcnt_q <= 11'h001 ##0
      ratio_q == $past(classify(mcnt_q, cfg.double_speed)))
    else $error("ratio count not restarted at frame");

endmodule
`default_nettype wire

// ==== mai_consts.svh ====
`ifndef MAI_CONSTS_SVH
`define MAI_CONSTS_SVH

`define MAI_SAMPLE_W 24
`define MAI_RJ16_W 16
`define MAI_OL1_SLOT_W 5'h14
`define MAI_OL2_SLOT_W 5'h18
`define MAI_TDM_SLOT_W 6'h20
`define MAI_OL1_HALF 8'h40
`define MAI_OL2_HALF 8'h80
`define MAI_OL_SLOTS 4'h6
`define MAI_TDM_SLOTS 4'h8
`define MAI_OL_SECOND_SLOT 4'h3
`define MAI_BIT_CNT_MAX 6'h3f
`define MAI_POS_MAX 8'hff
`define MAI_MCK_CNT_W 11
`define MAI_MCK_CNT_MAX 11'h7ff
`define MAI_THR_192 11'h0a0
`define MAI_THR_256 11'h0e0
`define MAI_THR_384 11'h140
`define MAI_THR_512 11'h1c0
`define MAI_THR_768 11'h280
`define MAI_THR_1024 11'h380
`define MAI_THR_NONE 11'h480
`define MAI_DEEMPH_K32 8'hb0
`define MAI_DEEMPH_K44 8'hc0
`define MAI_DEEMPH_K48 8'hc8
`define MAI_SAMPLE_RST 24'h000000

`endif

// ==== mai_pkg.sv ====
`include "mai_consts.svh"

package mai_pkg;

  typedef enum logic [2:0] {
    fmt_lj, fmt_i2s, fmt_rj16, fmt_rj24, fmt_ol1, fmt_ol2, fmt_tdm
  } mai_fmt_e;

  typedef enum logic [1:0] {deemph_off, deemph_32k, deemph_44k1, deemph_48k} mai_deemph_e;

  typedef enum logic [2:0] {
    ratio_128, ratio_192, ratio_256, ratio_384, ratio_512, ratio_768, ratio_1024, ratio_none
  } mai_ratio_e;

  typedef logic [`MAI_SAMPLE_W-1:0] mai_word_t;
  typedef logic [3:0][`MAI_SAMPLE_W-1:0] mai_chan_t;

  typedef struct packed {
    mai_fmt_e fmt;
    mai_deemph_e deemph;
    logic double_speed;
  } mai_cfg_s;

  typedef struct packed {
    logic fs;
    logic bck;
    logic mck;
    logic [3:0] sd;
  } mai_pins_s;

  typedef struct packed {
    mai_ratio_e ratio;
    logic locked;
    logic [4:0] div;
  } mai_rate_s;

endpackage

// ==== mai_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mai_src_model
  import mai_pkg::*;
(
  output mai_pins_s pins
);
  logic [7:0][23:0] ch;
  mai_fmt_e fmt;

  initial begin
    pins = '0;
    ch = '0;
    fmt = fmt_lj;
  end

  // Bit clocks per frame
  function automatic int flen(mai_fmt_e f);
    case (f)
      fmt_ol1: return 128;
      fmt_ol2, fmt_tdm: return 256;
      default: return 64;
    endcase
  endfunction

  function automatic logic fsv(int p);
    int n;
    n = flen(fmt);
    if (fmt == fmt_tdm) return p == n - 1;
    if (fmt == fmt_i2s) return p >= n / 2;
    return p < n / 2;
  endfunction

  // Unused lines toggle every bit so that a leak into the outputs shows up
  function automatic logic bitv(int l, int p);
    int h, o, s, w;
    h = 4 * int'(p >= flen(fmt) / 2);
    o = p % (flen(fmt) / 2);
    if (fmt == fmt_tdm) begin
      if (l != 0) return p[0];
      o = p % 32;
      return (o < 24) ? ch[p / 32][23 - o] : 1'b0;
    end
    if (fmt == fmt_ol1 || fmt == fmt_ol2) begin
      w = (fmt == fmt_ol1) ? 20 : 24;
      s = o / w;
      if (l == 1 || l == 2) return p[0];
      if (s > 2 || (l == 3 && s != 0)) return 1'b0;
      return ch[(l == 3 ? 3 : s) + h][23 - o % w];
    end
    if (fmt == fmt_i2s) o = o - 1;
    if (fmt == fmt_rj24) o = o - 8;
    if (fmt == fmt_rj16) o = o - 16;
    return (o >= 0 && o < 24) ? ch[l + h][23 - o] : 1'b0;
  endfunction

  task automatic mck_cycles(int k);
    repeat (2 * k) #312.5 pins.mck = ~pins.mck;
  endtask

  // Bit clock and master clock stand still between bursts; data inverts
  task automatic send(int nf);
    int n;
    n = flen(fmt);
    #13;
    for (int q = -1; q <= nf * n; q++) begin
      pins.bck = 1'b0;
      pins.fs = fsv((q + n) % n);
      for (int l = 0; l < 4; l++) pins.sd[l] = bitv(l, (q + n) % n);
      mck_cycles(2);
      pins.bck = 1'b1;
      mck_cycles(2);
    end
    pins.bck = 1'b0;
    pins.sd = ~pins.sd;
  endtask
endmodule
`default_nettype wire

// ==== multichannel_audio_serial_input_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module multichannel_audio_serial_input_tb_top import mai_pkg::*;;
  logic ref_clk;
  logic reset;
  mai_cfg_s cfg;
  mai_pins_s pins;
  mai_chan_t out_a;
  mai_chan_t out_b;
  mai_rate_s rate_st;
  logic frame_valid;
  logic conv_tick;
  logic [7:0][23:0] vals;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_fv = 0;
  int n_tick = 0;
  mai_ratio_e tick_ratio = ratio_none;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  mai_src_model src_u (.pins(pins));

  mai_audio_input_port dut_u (
    .ref_clk(ref_clk),
    .reset(reset),
    .frame_sync_in(pins.fs),
    .serial_bit_clock_in(pins.bck),
    .audio_master_clock_in(pins.mck),
    .serial_audio_in_1(pins.sd[0]),
    .serial_audio_in_2(pins.sd[1]),
    .serial_audio_in_3(pins.sd[2]),
    .serial_audio_in_4(pins.sd[3]),
    .cfg(cfg),
    .output_channel_a(out_a),
    .output_channel_b(out_b),
    .frame_valid(frame_valid),
    .rate_status(rate_st),
    .rate_conv_tick(conv_tick)
  );

  always @(posedge ref_clk) begin
    if (frame_valid === 1'b1) n_fv <= n_fv + 1;
    if (conv_tick === 1'b1 && rate_st.ratio == tick_ratio) n_tick <= n_tick + 1;
  end

  task automatic chk(logic [23:0] got, logic [23:0] exp, string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset(int n);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(out_a[0] | out_b[3], 24'h0, "reset sample");
    chk({21'h0, rate_st.ratio}, {21'h0, ratio_none}, "reset ratio");
  endtask

  // Ticks count only while the expected ratio stands: a short first period
  // can lock a faster divider for a frame, which says nothing about this ratio
  task automatic run(mai_fmt_e f, logic ds, mai_deemph_e de, int nf, mai_ratio_e r, int d);
    int fv0, tk0, m, lo, hi, xi, dv;
    logic [23:0] e;
    @(posedge ref_clk);
    cfg <= '{fmt: f, deemph: de, double_speed: ds};
    src_u.fmt = f;
    src_u.ch = vals;
    repeat (4) @(posedge ref_clk);
    fv0 = n_fv;
    tick_ratio = r;
    tk0 = n_tick;
    src_u.send(nf);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(24'(n_fv - fv0 >= nf && n_fv - fv0 <= nf + 1), 24'h1, "frames");
    for (int c = 0; c < 8; c++) begin
      e = vals[c];
      if (f == fmt_rj16) e[7:0] = 8'h00;
      if (f == fmt_ol1) e[3:0] = 4'h0;
      if (de == deemph_off) chk(c < 4 ? out_a[c] : out_b[c - 4], e, "channel");
    end
    xi = $signed(vals[0]);
    dv = xi - $signed(out_a[0]);
    if (de != deemph_off) chk(24'(dv != 0 && dv > xi / 8 && dv < -xi / 8), 24'h1, "deemph");
    chk({21'h0, rate_st.ratio}, {21'h0, r}, "ratio");
    chk({23'h0, rate_st.locked}, {23'h0, r != ratio_none}, "locked");
    chk({19'h0, rate_st.div}, 24'(d), "divider");
    m = 4 * src_u.flen(f);
    lo = d ? (nf - 1) * m / d / 2 - 2 : 0;
    hi = d ? nf * m / d + 2 : 1;
    tk0 = n_tick - tk0;
    chk(24'(tk0 >= lo && tk0 <= hi), 24'h1, "ticks");
  endtask

  initial begin
    reset = 1'b1;
    cfg = '0;
    for (int c = 0; c < 8; c++) vals[c] = 24'h9a5c31 ^ 24'(24'h151515 * c);
    do_reset(16);
    run(fmt_lj, 1'b0, deemph_off, 2, ratio_256, 4);
    run(fmt_i2s, 1'b0, deemph_off, 2, ratio_256, 4);
    run(fmt_rj16, 1'b0, deemph_off, 2, ratio_256, 4);
    run(fmt_rj24, 1'b0, deemph_off, 2, ratio_256, 4);
    run(fmt_ol1, 1'b1, deemph_off, 2, ratio_512, 8);
    run(fmt_ol2, 1'b1, deemph_off, 2, ratio_none, 0);
    run(fmt_tdm, 1'b0, deemph_off, 2, ratio_1024, 16);
    // Filter state survives frames, so each setting starts from reset
    for (int i = 1; i < 4; i++) begin
      do_reset(4);
      run(fmt_lj, 1'b0, mai_deemph_e'(i), 3, ratio_256, 4);
    end
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    $display("mismatch at %0t: run timed out", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
